// ---- inc/wsgr_pkg.sv ----
// Constants, field positions and register indices for the watchdog control,
// soft-power delay and pin readback block.
// Assumes a 25 MHz device clock; registers are 8 bits in lane 0 of 32-bit words.
package wsgr_pkg;

  // ==========================================================================
  // Clock and times
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned DELAY_UNIT_MS = 10;
  localparam int unsigned DELAY_UNIT_CYCLES = CLK_HZ / 1000 * DELAY_UNIT_MS;
  localparam int unsigned LED_HALF_MS = 500;
  localparam int unsigned LED_HALF_CYCLES = CLK_HZ / 1000 * LED_HALF_MS;
  localparam int unsigned KBC_MIN_HIGH_NS = 1000;
  localparam int unsigned KBC_MIN_HIGH_CYCLES = (KBC_MIN_HIGH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_WATCHDOG_CONTROL = 8'hf4;
  localparam logic [7:0] IDX_FIRST_BANK = 8'hf6;
  localparam logic [7:0] IDX_FIFTH_BANK = 8'hf9;
  localparam logic [7:0] IDX_SIXTH_BANK = 8'hfa;
  localparam logic [7:0] IDX_DELAY_TIME = 8'hb8;
  localparam logic [7:0] IDX_MODE = 8'h20;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h21;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h22;
  localparam logic [7:0] IDX_FIRST_IRQ_EN = 8'h23;
  localparam logic [7:0] IDX_FIFTH_IRQ_EN = 8'h24;
  localparam logic [7:0] IDX_SIXTH_IRQ_EN = 8'h25;
  localparam logic [7:0] IDX_SOFT_PWR_EN = 8'h26;
  localparam logic [7:0] IDX_SOFT_PWR_STATUS = 8'h27;
  localparam logic [7:0] MIR_FIRST_BANK = 8'h01;
  localparam logic [7:0] MIR_WATCHDOG_CONTROL = 8'h02;
  localparam logic [7:0] MIR_FIFTH_BANK = 8'h03;
  localparam logic [7:0] MIR_SIXTH_BANK = 8'h04;
  localparam logic [7:0] MIR_SOFT_PWR_EN = 8'h05;
  localparam logic [7:0] MIR_SOFT_PWR_STATUS = 8'h06;

  // ==========================================================================
  // Watchdog control fields
  localparam int unsigned WDC_STATUS = 0;
  localparam int unsigned WDC_LED_EN = 1;
  localparam int unsigned WDC_FORCE = 2;
  localparam int unsigned WDC_KBC_EN = 3;
  localparam int unsigned WDC_STOP = 5;
  localparam int unsigned WDC_RESTART = 6;
  localparam int unsigned WDC_SOFTWARE_POWER_OFF = 7;

  // Interrupt status bits
  localparam int unsigned IRQ_WD_TIMEOUT = 0;
  localparam int unsigned IRQ_POWER_DOWN = 1;
  localparam int unsigned IRQ_BUTTON = 2;

  // ==========================================================================
  // Reset values and layouts
  localparam logic [7:0] DELAY_TIME_RESET = 8'h32;
  localparam logic [4:0] FIFTH_BANK_MASK = 5'h1d;

  typedef enum {
    WSGR_REG_NONE, WSGR_REG_FIRST, WSGR_REG_FIFTH, WSGR_REG_SIXTH, WSGR_REG_WDC,
    WSGR_REG_DELAY, WSGR_REG_MODE, WSGR_REG_IST, WSGR_REG_IMSK, WSGR_REG_IEN1,
    WSGR_REG_IEN5, WSGR_REG_IEN6, WSGR_REG_SPEN, WSGR_REG_SPST
  } wsgr_reg_t;

endpackage

// ---- hw/wsgr_top.sv ----
// Watchdog control upper bits, soft-power button delay and GPIO pin readback,
// reached over an Avalon-MM slave with waitrequest.
// Assumes pins and the keyboard-port line are asynchronous to ref_clk_in.
//
// Notes on behaviour
// - Enabled keyboard-port rising edge forces watchdog timeout.
// - Software force bit works regardless of enable.
// - Disabled keyboard-port line never causes timeout.
// - Self-clearing edge detect ORed with software force.
// - Abort bit ends delay without power down.
// - Abort bit reads zero running, one stopped.
// - Restart bit restarts delay from zero, self-clears.
// - Restarts accepted without limit.
// - Software power-off bit forces immediate power down.
// - Delay length from programmable delay-time register.
// - Readback registers show live pins, reserved zero.
// - Low-index mirrors exist outside configuration mode.
// - First bank pins enableable onto combined interrupt one.
// - Fifth, sixth bank pins onto combined interrupt two.
// - Watchdog status reads one after timeout.
// - Force bit generates timeout then self-clears.
// - LED blinks at 1 Hz, toggling every 1/2 s, when enabled and watchdog status set.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

module wsgr_top #(
  parameter int unsigned DELAY_UNIT_CYC = wsgr_pkg::DELAY_UNIT_CYCLES,
  parameter int unsigned LED_HALF_CYC = wsgr_pkg::LED_HALF_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic kbc_port_force_line_in,
  input wire logic power_button_in,
  input wire logic [7:0] first_bank_pins_in,
  input wire logic [4:0] fifth_bank_pins_in,
  input wire logic [7:0] sixth_bank_pins_in,
  output logic wd_timeout_event_out,
  output logic power_down_out,
  output logic power_indicator_output_out,
  output logic combined_pin_irq_one_out,
  output logic combined_pin_irq_two_out,
  output logic irq_out
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic kbc_s1;
    logic kbc_s2;
    logic kbc_prev;
    logic btn_s1;
    logic btn_s2;
    logic btn_prev;
    logic [7:0] p1_s1;
    logic [7:0] p1_s2;
    logic [4:0] p5_s1;
    logic [4:0] p5_s2;
    logic [7:0] p6_s1;
    logic [7:0] p6_s2;
    logic wait_req;
    logic [31:0] rdata;
    logic wd_status;
    logic led_en;
    logic kbc_en;
    logic cfg_mode;
    logic [2:0] irq_st;
    logic [2:0] irq_msk;
    logic [7:0] en1;
    logic [4:0] en5;
    logic [7:0] en6;
    logic sp_en;
    logic [7:0] dly_val;
    logic dly_run;
    logic [23:0] tick_cnt;
    logic [7:0] unit_cnt;
    logic [23:0] led_cnt;
    logic led;
    logic wd_event;
    logic pdown;
    logic irq;
    logic cirq1;
    logic cirq2;
  } wsgr_state_t;

  wsgr_state_t s_q;
  wsgr_state_t s_d;

  // ==========================================================================
  // Address decode, shared by reads and writes
  function automatic wsgr_pkg::wsgr_reg_t map_index(input logic [7:0] idx, input logic cfg);
    wsgr_pkg::wsgr_reg_t r;
    r = wsgr_pkg::WSGR_REG_NONE;
    unique case (idx)
      wsgr_pkg::IDX_FIRST_BANK: r = wsgr_pkg::WSGR_REG_FIRST;
      wsgr_pkg::IDX_FIFTH_BANK: r = wsgr_pkg::WSGR_REG_FIFTH;
      wsgr_pkg::IDX_SIXTH_BANK: r = wsgr_pkg::WSGR_REG_SIXTH;
      wsgr_pkg::IDX_WATCHDOG_CONTROL: r = wsgr_pkg::WSGR_REG_WDC;
      wsgr_pkg::IDX_DELAY_TIME: r = wsgr_pkg::WSGR_REG_DELAY;
      wsgr_pkg::IDX_MODE: r = wsgr_pkg::WSGR_REG_MODE;
      wsgr_pkg::IDX_IRQ_STATUS: r = wsgr_pkg::WSGR_REG_IST;
      wsgr_pkg::IDX_IRQ_MASK: r = wsgr_pkg::WSGR_REG_IMSK;
      wsgr_pkg::IDX_FIRST_IRQ_EN: r = wsgr_pkg::WSGR_REG_IEN1;
      wsgr_pkg::IDX_FIFTH_IRQ_EN: r = wsgr_pkg::WSGR_REG_IEN5;
      wsgr_pkg::IDX_SIXTH_IRQ_EN: r = wsgr_pkg::WSGR_REG_IEN6;
      wsgr_pkg::IDX_SOFT_PWR_EN: r = wsgr_pkg::WSGR_REG_SPEN;
      wsgr_pkg::IDX_SOFT_PWR_STATUS: r = wsgr_pkg::WSGR_REG_SPST;
      // Mirrors vanish in configuration mode
      wsgr_pkg::MIR_FIRST_BANK: r = cfg ? wsgr_pkg::WSGR_REG_NONE : wsgr_pkg::WSGR_REG_FIRST;
      wsgr_pkg::MIR_WATCHDOG_CONTROL: r = cfg ? wsgr_pkg::WSGR_REG_NONE : wsgr_pkg::WSGR_REG_WDC;
      wsgr_pkg::MIR_FIFTH_BANK: r = cfg ? wsgr_pkg::WSGR_REG_NONE : wsgr_pkg::WSGR_REG_FIFTH;
      wsgr_pkg::MIR_SIXTH_BANK: r = cfg ? wsgr_pkg::WSGR_REG_NONE : wsgr_pkg::WSGR_REG_SIXTH;
      wsgr_pkg::MIR_SOFT_PWR_EN: r = cfg ? wsgr_pkg::WSGR_REG_NONE : wsgr_pkg::WSGR_REG_SPEN;
      wsgr_pkg::MIR_SOFT_PWR_STATUS: r = cfg ? wsgr_pkg::WSGR_REG_NONE : wsgr_pkg::WSGR_REG_SPST;
      default: r = wsgr_pkg::WSGR_REG_NONE;
    endcase
    return r;
  endfunction

  logic kbc_rise;
  logic btn_rise;
  logic acc_wr;
  logic [7:0] wd;
  logic [7:0] rval;
  logic [4:0] p5_live;
  logic wdc_wr;
  logic force_wr;
  logic button_start;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  wsgr_pkg::wsgr_reg_t reg_id;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Two-stage synchronisers; only stage two feeds logic
    s_d.kbc_s1 = kbc_port_force_line_in;
    s_d.kbc_s2 = s_q.kbc_s1;
    s_d.kbc_prev = s_q.kbc_s2;
    s_d.btn_s1 = power_button_in;
    s_d.btn_s2 = s_q.btn_s1;
    s_d.btn_prev = s_q.btn_s2;
    s_d.p1_s1 = first_bank_pins_in;
    s_d.p1_s2 = s_q.p1_s1;
    s_d.p5_s1 = fifth_bank_pins_in;
    s_d.p5_s2 = s_q.p5_s1;
    s_d.p6_s1 = sixth_bank_pins_in;
    s_d.p6_s2 = s_q.p6_s1;

    kbc_rise = s_q.kbc_s2 & ~s_q.kbc_prev;
    btn_rise = s_q.btn_s2 & ~s_q.btn_prev;
    p5_live = s_q.p5_s2 & wsgr_pkg::FIFTH_BANK_MASK;
    reg_id = map_index(avs_address_in[9:2], s_q.cfg_mode);
    wd = avs_writedata_in[7:0];
    // A write lands at the edge where waitrequest is seen low
    acc_wr = avs_write_in && !s_q.wait_req && avs_byteenable_in[0];
    wdc_wr = acc_wr && (reg_id == wsgr_pkg::WSGR_REG_WDC);
    force_wr = wdc_wr && wd[wsgr_pkg::WDC_FORCE];

    // Held-high line gives one pulse only; ORed with the software force
    s_d.wd_event = (kbc_rise && s_q.kbc_en) || force_wr;

    // Bus handshake: one wait cycle, then the answer
    s_d.wait_req = !((avs_read_in || avs_write_in) && s_q.wait_req);

    // Read mux; reserved and unmapped bits read zero
    rval = 8'h00;
    unique case (reg_id)
      wsgr_pkg::WSGR_REG_FIRST: rval = s_q.p1_s2;
      wsgr_pkg::WSGR_REG_FIFTH: rval = {3'h0, p5_live};
      wsgr_pkg::WSGR_REG_SIXTH: rval = s_q.p6_s2;
      wsgr_pkg::WSGR_REG_WDC: rval = {2'h0, ~s_q.dly_run, 1'b0, s_q.kbc_en, 1'b0, s_q.led_en, s_q.wd_status};
      wsgr_pkg::WSGR_REG_DELAY: rval = s_q.dly_val;
      wsgr_pkg::WSGR_REG_MODE: rval = {7'h00, s_q.cfg_mode};
      wsgr_pkg::WSGR_REG_IST: rval = {5'h00, s_q.irq_st};
      wsgr_pkg::WSGR_REG_IMSK: rval = {5'h00, s_q.irq_msk};
      wsgr_pkg::WSGR_REG_IEN1: rval = s_q.en1;
      wsgr_pkg::WSGR_REG_IEN5: rval = {3'h0, s_q.en5};
      wsgr_pkg::WSGR_REG_IEN6: rval = s_q.en6;
      wsgr_pkg::WSGR_REG_SPEN: rval = {7'h00, s_q.sp_en};
      wsgr_pkg::WSGR_REG_SPST: rval = {6'h00, s_q.irq_st[wsgr_pkg::IRQ_POWER_DOWN], s_q.dly_run};
      wsgr_pkg::WSGR_REG_NONE: rval = 8'h00;
    endcase
    if (avs_read_in && s_q.wait_req) begin
      s_d.rdata = {24'h000000, rval};
    end

    // Plain register writes; bit 4 of the control word is not stored
    irq_clr = 3'h0;
    if (acc_wr) begin
      unique case (reg_id)
        wsgr_pkg::WSGR_REG_WDC: begin
          s_d.led_en = wd[wsgr_pkg::WDC_LED_EN];
          s_d.kbc_en = wd[wsgr_pkg::WDC_KBC_EN];
        end
        wsgr_pkg::WSGR_REG_DELAY: s_d.dly_val = wd;
        wsgr_pkg::WSGR_REG_MODE: s_d.cfg_mode = wd[0];
        wsgr_pkg::WSGR_REG_IST: irq_clr = wd[2:0];
        wsgr_pkg::WSGR_REG_IMSK: s_d.irq_msk = wd[2:0];
        wsgr_pkg::WSGR_REG_IEN1: s_d.en1 = wd;
        wsgr_pkg::WSGR_REG_IEN5: s_d.en5 = wd[4:0];
        wsgr_pkg::WSGR_REG_IEN6: s_d.en6 = wd;
        wsgr_pkg::WSGR_REG_SPEN: s_d.sp_en = wd[0];
        default: begin
        end
      endcase
    end

    // Status may be written, but a timeout in the same cycle wins
    s_d.wd_status = (wdc_wr ? wd[wsgr_pkg::WDC_STATUS] : s_q.wd_status) | s_d.wd_event;

    // Button power-down delay
    s_d.pdown = 1'b0;
    button_start = btn_rise && s_q.sp_en && !s_q.dly_run;
    if (s_q.dly_run) begin
      if (s_q.unit_cnt == s_q.dly_val) begin
        s_d.pdown = 1'b1;
        s_d.dly_run = 1'b0;
      end else if (s_q.tick_cnt == 24'(DELAY_UNIT_CYC - 1)) begin
        s_d.tick_cnt = 24'h000000;
        s_d.unit_cnt = s_q.unit_cnt + 8'h01;
      end else begin
        s_d.tick_cnt = s_q.tick_cnt + 24'h000001;
      end
    end
    // Restart as often as software likes; the count always starts over
    if (button_start || (wdc_wr && wd[wsgr_pkg::WDC_RESTART])) begin
      s_d.dly_run = 1'b1;
      s_d.tick_cnt = 24'h000000;
      s_d.unit_cnt = 8'h00;
      s_d.pdown = 1'b0;
    end
    // Abort beats a restart written in the same word
    if (wdc_wr && wd[wsgr_pkg::WDC_STOP]) begin
      s_d.dly_run = 1'b0;
      s_d.pdown = 1'b0;
    end
    // Software power-off bypasses the delay
    if (wdc_wr && wd[wsgr_pkg::WDC_SOFTWARE_POWER_OFF]) begin
      s_d.dly_run = 1'b0;
      s_d.pdown = 1'b1;
    end

    // Sticky interrupt status, write one to clear, set wins
    irq_set = 3'h0;
    irq_set[wsgr_pkg::IRQ_WD_TIMEOUT] = s_d.wd_event;
    irq_set[wsgr_pkg::IRQ_POWER_DOWN] = s_d.pdown;
    irq_set[wsgr_pkg::IRQ_BUTTON] = button_start;
    s_d.irq_st = (s_q.irq_st & ~irq_clr) | irq_set;
    s_d.irq = |(s_q.irq_st & s_q.irq_msk);

    // LED blinks 1/2 s on, 1/2 s off while timed out and enabled
    if (s_q.led_en && s_q.wd_status) begin
      if (s_q.led_cnt == 24'(LED_HALF_CYC - 1)) begin
        s_d.led_cnt = 24'h000000;
        s_d.led = ~s_q.led;
      end else begin
        s_d.led_cnt = s_q.led_cnt + 24'h000001;
      end
    end else begin
      s_d.led_cnt = 24'h000000;
      s_d.led = 1'b0;
    end

    // Combined pin interrupts, one enable per pin
    s_d.cirq1 = |(s_q.p1_s2 & s_q.en1);
    s_d.cirq2 = |(p5_live & s_q.en5) | |(s_q.p6_s2 & s_q.en6);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      s_q <= '0;
      s_q.wait_req <= 1'b1;
      s_q.dly_val <= wsgr_pkg::DELAY_TIME_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_out = s_q.rdata;
  assign avs_waitrequest_out = s_q.wait_req;
  assign wd_timeout_event_out = s_q.wd_event;
  assign power_down_out = s_q.pdown;
  assign power_indicator_output_out = s_q.led;
  assign combined_pin_irq_one_out = s_q.cirq1;
  assign combined_pin_irq_two_out = s_q.cirq2;
  assign irq_out = s_q.irq;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  kbc_edge_a: assert property (s_q.kbc_s2 && !s_q.kbc_prev && s_q.kbc_en |=> wd_timeout_event_out)
    else $error("keyboard-port edge gave no timeout");
  kbc_masked_a: assert property (wd_timeout_event_out && !$past(force_wr) |-> $past(s_q.kbc_en))
    else $error("timeout from disabled keyboard-port line");
  force_bit_a: assert property (force_wr |=> wd_timeout_event_out ##1 !wd_timeout_event_out)
    else $error("force bit did not give one timeout pulse");
  one_pulse_a: assert property ($rose(s_q.kbc_s2) && !force_wr ##1 wd_timeout_event_out |=> !wd_timeout_event_out)
    else $error("keyboard-port edge gave more than one pulse");
  status_set_a: assert property (wd_timeout_event_out |-> s_q.wd_status)
    else $error("timeout did not set watchdog status");
  abort_read_a: assert property (avs_read_in && s_q.wait_req && reg_id == wsgr_pkg::WSGR_REG_WDC
    |=> avs_readdata_out[wsgr_pkg::WDC_STOP] == $past(!s_q.dly_run))
    else $error("abort bit read does not show counter state");
  abort_a: assert property (wdc_wr && wd[wsgr_pkg::WDC_STOP] && !wd[wsgr_pkg::WDC_SOFTWARE_POWER_OFF]
    |=> !s_q.dly_run && !power_down_out)
    else $error("abort did not stop delay quietly");
  restart_a: assert property (wdc_wr && wd[wsgr_pkg::WDC_RESTART] && !wd[wsgr_pkg::WDC_STOP] && !wd[wsgr_pkg::WDC_SOFTWARE_POWER_OFF]
    |=> s_q.dly_run && s_q.unit_cnt == 8'h00 && s_q.tick_cnt == 24'h000000)
    else $error("restart did not clear the delay");
  software_power_off_a: assert property (wdc_wr && wd[wsgr_pkg::WDC_SOFTWARE_POWER_OFF] |=> power_down_out)
    else $error("software power-off not immediate");
  delay_end_a: assert property (s_q.dly_run && s_q.unit_cnt == s_q.dly_val && !acc_wr |=> power_down_out)
    else $error("delay expiry gave no power down");
  fifth_resv_a: assert property (avs_read_in && s_q.wait_req && reg_id == wsgr_pkg::WSGR_REG_FIFTH
    |=> avs_readdata_out[7:5] == 3'h0 && !avs_readdata_out[1])
    else $error("reserved readback bits not zero");
  mirror_a: assert property (s_q.cfg_mode && avs_address_in[9:2] == wsgr_pkg::MIR_WATCHDOG_CONTROL
    |-> reg_id == wsgr_pkg::WSGR_REG_NONE)
    else $error("mirror visible in configuration mode");
  cirq_one_a: assert property (combined_pin_irq_one_out == $past(|(s_q.p1_s2 & s_q.en1)))
    else $error("combined interrupt one wrong");
  led_off_a: assert property (!(s_q.led_en && s_q.wd_status) |=> !power_indicator_output_out)
    else $error("LED toggles while disabled");
  force_clear_a: assert property (avs_read_in && s_q.wait_req && reg_id == wsgr_pkg::WSGR_REG_WDC
    |=> avs_readdata_out[7:6] == 2'h0 && !avs_readdata_out[4] && !avs_readdata_out[2])
    else $error("write-only control bits do not read zero");
  kbc_off_a: assert property (!s_q.kbc_en && !force_wr |=> !wd_timeout_event_out)
    else $error("timeout with keyboard-port force disabled");
  held_line_a: assert property (s_q.kbc_s2 && s_q.kbc_prev && !force_wr |=> !wd_timeout_event_out)
    else $error("held keyboard-port line gave a timeout");
  status_hold_a: assert property (s_q.wd_status && !wdc_wr |=> s_q.wd_status)
    else $error("watchdog status lost without a write");
  restart_run_a: assert property (s_q.dly_run && wdc_wr && wd[wsgr_pkg::WDC_RESTART]
    && !wd[wsgr_pkg::WDC_SOFTWARE_POWER_OFF] |=> !power_down_out)
    else $error("restart while running gave a power down");
  first_read_a: assert property (avs_read_in && s_q.wait_req && reg_id == wsgr_pkg::WSGR_REG_FIRST
    |=> avs_readdata_out == {24'h000000, $past(s_q.p1_s2)})
    else $error("first bank readback wrong");
  sixth_read_a: assert property (avs_read_in && s_q.wait_req && reg_id == wsgr_pkg::WSGR_REG_SIXTH
    |=> avs_readdata_out == {24'h000000, $past(s_q.p6_s2)})
    else $error("sixth bank readback wrong");
  mirror_on_a: assert property (!s_q.cfg_mode && avs_address_in[9:2] == wsgr_pkg::MIR_WATCHDOG_CONTROL
    |-> reg_id == wsgr_pkg::WSGR_REG_WDC)
    else $error("mirror hidden outside configuration mode");
  cirq_one_off_a: assert property (s_q.en1 == 8'h00 |=> !combined_pin_irq_one_out)
    else $error("combined interrupt one with no pin enabled");
  cirq_two_off_a: assert property (s_q.en5 == 5'h00 && s_q.en6 == 8'h00 |=> !combined_pin_irq_two_out)
    else $error("combined interrupt two with no pin enabled");
  led_toggle_a: assert property (s_q.led_en && s_q.wd_status && s_q.led_cnt == 24'(LED_HALF_CYC - 1)
    |=> power_indicator_output_out != $past(power_indicator_output_out))
    else $error("LED did not toggle at half period");
  wait_one_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");

endmodule

`default_nettype wire

// ---- bench/test_watchdog_softpower_gpio_readback.sv ----
// Self-checking bench for the watchdog control, soft-power delay and pin readback block.
// Assumes wsgr_top with short delay and LED counts; bench acts as Avalon-MM master and drives all pins.
`timescale 1ns/100ps
`default_nettype none

module test_watchdog_softpower_gpio_readback;
  localparam int unsigned UNIT = 4;
  localparam int unsigned HALF = 4;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [9:0] avs_address_in = 10'h000;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic kbc_port_force_line_in = 1'b0;
  logic power_button_in = 1'b0;
  logic [7:0] first_bank_pins_in = 8'h00;
  logic [4:0] fifth_bank_pins_in = 5'h00;
  logic [7:0] sixth_bank_pins_in = 8'h00;
  logic wd_timeout_event_out, power_down_out, power_indicator_output_out;
  logic combined_pin_irq_one_out, combined_pin_irq_two_out, irq_out;
  int miscompares = 0;
  int checked = 0;
  int wd_cnt = 0;
  int pd_cnt = 0;
  int led_cnt = 0;
  int cyc = 0;
  logic led_prev = 1'b0;
  logic [7:0] rd;

  wsgr_top #(.DELAY_UNIT_CYC(UNIT), .LED_HALF_CYC(HALF)) dut (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .kbc_port_force_line_in(kbc_port_force_line_in),
    .power_button_in(power_button_in), .first_bank_pins_in(first_bank_pins_in),
    .fifth_bank_pins_in(fifth_bank_pins_in), .sixth_bank_pins_in(sixth_bank_pins_in),
    .wd_timeout_event_out(wd_timeout_event_out), .power_down_out(power_down_out),
    .power_indicator_output_out(power_indicator_output_out),
    .combined_pin_irq_one_out(combined_pin_irq_one_out),
    .combined_pin_irq_two_out(combined_pin_irq_two_out), .irq_out(irq_out));

  // ==========================================================================
  // Clock, pulse counters and hang guard
  always #20 ref_clk_in = ~ref_clk_in;

  always @(posedge ref_clk_in) begin
    cyc++;
    if (wd_timeout_event_out === 1'b1) wd_cnt++;
    if (power_down_out === 1'b1) pd_cnt++;
    if (power_indicator_output_out !== led_prev) led_cnt++;
    led_prev = power_indicator_output_out;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end

  // ==========================================================================
  // Access tasks and comparison
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request raised after an edge and held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    avs_address_in <= {idx, 2'b00};
    avs_writedata_in <= {24'h0, wd};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    q = avs_readdata_out[7:0];
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (n >= 50) chk("waitrequest", 8'h00, 8'h01);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] q;
    bus(1'b1, idx, wd, q);
  endtask

  task automatic rc(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(what, exp, q);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  // ==========================================================================
  // Test sequence
  initial begin
    int w0;
    int p0;
    repeat (20) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    rc("delay reset", wsgr_pkg::IDX_DELAY_TIME, 8'h32);
    rc("wdc reset", wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h20);
    rc("first reset", wsgr_pkg::IDX_FIRST_BANK, 8'h00);
    $display("test reset done");

    first_bank_pins_in <= 8'ha5;
    fifth_bank_pins_in <= 5'h1f;
    sixth_bank_pins_in <= 8'h3c;
    cycles(4);
    rc("first", wsgr_pkg::IDX_FIRST_BANK, 8'ha5);
    rc("fifth", wsgr_pkg::IDX_FIFTH_BANK, 8'h1d);
    rc("sixth", wsgr_pkg::IDX_SIXTH_BANK, 8'h3c);
    wr(wsgr_pkg::IDX_FIRST_BANK, 8'h00);
    rc("first ro", wsgr_pkg::IDX_FIRST_BANK, 8'ha5);
    rc("mir first", wsgr_pkg::MIR_FIRST_BANK, 8'ha5);
    rc("mir fifth", wsgr_pkg::MIR_FIFTH_BANK, 8'h1d);
    rc("mir sixth", wsgr_pkg::MIR_SIXTH_BANK, 8'h3c);
    avs_byteenable_in <= 4'he;
    wr(wsgr_pkg::IDX_DELAY_TIME, 8'h77);
    avs_byteenable_in <= 4'hf;
    rc("lane off", wsgr_pkg::IDX_DELAY_TIME, 8'h32);
    wr(8'h10, 8'hff);
    rc("unmapped", 8'h10, 8'h00);
    wr(wsgr_pkg::IDX_MODE, 8'h01);
    rc("mir hidden", wsgr_pkg::MIR_FIRST_BANK, 8'h00);
    wr(wsgr_pkg::IDX_MODE, 8'h00);
    $display("test readback done");

    // Force with the keyboard enable off, first unmasked then masked in
    w0 = wd_cnt;
    wr(wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h04);
    cycles(3);
    chk("force pulse", 8'(w0 + 1), 8'(wd_cnt));
    chk("irq unmasked", 8'h00, {7'h0, irq_out});
    rc("wdc after force", wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h21);
    rc("mir wdc", wsgr_pkg::MIR_WATCHDOG_CONTROL, 8'h21);
    wr(wsgr_pkg::IDX_IRQ_STATUS, 8'h01);
    wr(wsgr_pkg::IDX_IRQ_MASK, 8'h01);
    wr(wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h04);
    cycles(3);
    chk("irq raised", 8'h01, {7'h0, irq_out});
    wr(wsgr_pkg::IDX_IRQ_STATUS, 8'h01);
    cycles(3);
    chk("irq cleared", 8'h00, {7'h0, irq_out});
    wr(wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h00);
    rc("status cleared", wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h20);
    $display("test force done");

    // Keyboard line: ignored when disabled, one pulse per rise when enabled
    w0 = wd_cnt;
    kbc_port_force_line_in <= 1'b1;
    cycles(30);
    kbc_port_force_line_in <= 1'b0;
    cycles(5);
    chk("kbc disabled", 8'(w0), 8'(wd_cnt));
    wr(wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h08);
    rc("kbc enable", wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h28);
    cycles(2);
    kbc_port_force_line_in <= 1'b1;
    cycles(40);
    chk("kbc one pulse", 8'(w0 + 1), 8'(wd_cnt));
    kbc_port_force_line_in <= 1'b0;
    cycles(5);
    kbc_port_force_line_in <= 1'b1;
    cycles(10);
    chk("kbc second", 8'(w0 + 2), 8'(wd_cnt));
    kbc_port_force_line_in <= 1'b0;
    wr(wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h00);
    $display("test keyboard done");

    // Button delay of 10 units held off by restarts, then aborted
    wr(wsgr_pkg::IDX_DELAY_TIME, 8'h0a);
    wr(wsgr_pkg::IDX_SOFT_PWR_EN, 8'h01);
    p0 = pd_cnt;
    power_button_in <= 1'b1;
    cycles(6);
    rc("running", wsgr_pkg::MIR_SOFT_PWR_STATUS, 8'h01);
    rc("abort reads run", wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h00);
    repeat (6) begin
      wr(wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h40);
      cycles(20);
    end
    chk("restart holds off", 8'(p0), 8'(pd_cnt));
    wr(wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h20);
    rc("abort reads stop", wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h20);
    cycles(80);
    chk("abort no power down", 8'(p0), 8'(pd_cnt));
    power_button_in <= 1'b0;
    cycles(5);
    power_button_in <= 1'b1;
    cycles(10);
    chk("not yet", 8'(p0), 8'(pd_cnt));
    cycles(60);
    chk("delay ends", 8'(p0 + 1), 8'(pd_cnt));
    rc("pd status", wsgr_pkg::IDX_SOFT_PWR_STATUS, 8'h02);
    power_button_in <= 1'b0;
    wr(wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h80);
    cycles(3);
    chk("soft off", 8'(p0 + 2), 8'(pd_cnt));
    rc("bits self clear", wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h20);
    $display("test delay done");

    // LED toggles every HALF cycles while enabled and status set
    chk("led idle", 8'h00, {7'h0, power_indicator_output_out});
    wr(wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h06);
    cycles(4);
    led_cnt = 0;
    cycles(40);
    chk("led toggles", 8'(40 / HALF), 8'(led_cnt));
    wr(wsgr_pkg::IDX_WATCHDOG_CONTROL, 8'h00);
    $display("test led done");

    // Combined pin interrupts
    wr(wsgr_pkg::IDX_FIRST_IRQ_EN, 8'h04);
    cycles(3);
    chk("irq one on", 8'h01, {7'h0, combined_pin_irq_one_out});
    wr(wsgr_pkg::IDX_FIRST_IRQ_EN, 8'h02);
    cycles(3);
    chk("irq one off", 8'h00, {7'h0, combined_pin_irq_one_out});
    wr(wsgr_pkg::IDX_SIXTH_IRQ_EN, 8'h80);
    cycles(3);
    chk("irq two off", 8'h00, {7'h0, combined_pin_irq_two_out});
    wr(wsgr_pkg::IDX_FIFTH_IRQ_EN, 8'h01);
    cycles(3);
    chk("irq two on", 8'h01, {7'h0, combined_pin_irq_two_out});
    $display("test combined irq done");
    final_report();
  end
endmodule

`default_nettype wire
